// ===== pkg/bxt_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef BXT_REGS_SVH
`define BXT_REGS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define BXT_ADDR_W            5
`define BXT_DATA_W            16
`define BXT_OFS_LINE_TEST     5'h1B
`define BXT_LINE_TEST_RESET   16'h0000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BXT_ERRCNT_MSB        15
`define BXT_ERRCNT_LSB        8
`define BXT_RSVD_HI_MSB       7
`define BXT_RSVD_HI_LSB       6
`define BXT_CONT_BIT          5
`define BXT_PATEN_BIT         4
`define BXT_RSVD_LO_BIT       3
`define BXT_GAPSEL_BIT        2
`define BXT_PATSEL_MSB        1
`define BXT_PATSEL_LSB        0
`define BXT_ERRCNT_MAX        8'hFF

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BXT_CLK_PERIOD_NS     5
`define BXT_HALF_BIT_NS       50
`define BXT_HALF_BIT_CYC      ((`BXT_HALF_BIT_NS + `BXT_CLK_PERIOD_NS - 1) \
                               / `BXT_CLK_PERIOD_NS)
`define BXT_GAP_SHORT_US      10
`define BXT_GAP_LONG_US       15
`define BXT_GAP_SHORT_CYC     ((`BXT_GAP_SHORT_US * 1000) / `BXT_CLK_PERIOD_NS)
`define BXT_GAP_LONG_CYC      ((`BXT_GAP_LONG_US * 1000) / `BXT_CLK_PERIOD_NS)
`define BXT_DATA_HALVES       8'h80
`define BXT_EOP_HALVES        8'h04
`define BXT_NLP_HALVES        8'h02
`define BXT_LFSR_SEED         9'h1FF

`endif

// ===== pkg/bxt_pkg.sv
// Types used by the line test pattern logic.
package bxt_pkg;

  // --------------------------------------------------------------------------
  // Pattern generator states and pattern selections
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PG_OFF,
    PG_DATA,
    PG_EOP,
    PG_NLP,
    PG_GAP,
    PG_TONE
  } bxt_pg_state_t;

  typedef enum logic [1:0] {
    PAT_DATA_END_OF_PACKET_VARIANT_0 = 2'h0,
    PAT_DATA_END_OF_PACKET_VARIANT_1 = 2'h1,
    PAT_NLP       = 2'h2,
    PAT_TONE      = 2'h3
  } bxt_pat_sel_t;

endpackage : bxt_pkg

// ===== hdl/bxt_tick_div.sv
// Divider that makes a one-cycle enable pulse every DIV cycles.
module bxt_tick_div #(
  parameter int DIV = 10
) (
  // Clock and reset
  input  wire logic REF_CLK,
  input  wire logic RESET,
  // Control
  input  wire logic run,
  output logic      tick
);

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_r;

  // The count restarts whenever run drops, so phases align to the start.
  always_ff @(posedge REF_CLK) begin
    if (RESET || !run) begin
      cnt_r <= '0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  assign tick = run && (cnt_r == LAST);

endmodule : bxt_tick_div

// ===== hdl/bxt_top.sv
// Self-test error counter, continuous mode and 10 Mb/s line test patterns.
`include "bxt_regs.svh"

module bxt_top (
  // Clock and reset
  input  wire logic                   REF_CLK,
  input  wire logic                   RESET,
  // Management register port
  input  wire logic [`BXT_ADDR_W-1:0] REG_ADDR,
  input  wire logic [`BXT_DATA_W-1:0] REG_WDATA,
  input  wire logic                   REG_WE,
  input  wire logic                   REG_RE,
  output logic      [`BXT_DATA_W-1:0] REG_RDATA,
  output logic                        REG_RVALID,
  // Packet self-test engine
  input  wire logic                   SELFTEST_START,
  input  wire logic                   SELFTEST_ACTIVE,
  input  wire logic                   SELFTEST_RX_NIBBLE_ERR,
  output logic                        SELFTEST_CONTINUOUS_TX,
  // Twisted-pair pattern path
  output logic                        LINE_PATTERN_ACTIVE,
  output logic                        LINE_PATTERN_DATA
);

  import bxt_pkg::*;

  // --------------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------------
  localparam logic [11:0] GAP_SHORT = 12'(`BXT_GAP_SHORT_CYC - 1);
  localparam logic [11:0] GAP_LONG  = 12'(`BXT_GAP_LONG_CYC - 1);
  localparam logic [7:0]  DATA_LAST = `BXT_DATA_HALVES - 8'h01;
  localparam logic [7:0]  EOP_END   = `BXT_EOP_HALVES;
  localparam logic [7:0]  NLP_END   = `BXT_NLP_HALVES;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic                   hit_w;
  logic [7:0]             err_cnt_r;
  logic [1:0]             rsvd_hi_r;
  logic                   cont_r;
  logic                   pat_en_r;
  logic                   rsvd_lo_r;
  logic                   gap_sel_r;
  bxt_pat_sel_t           pat_sel_r;
  bxt_pat_sel_t           run_sel_r;
  logic                   run_r;
  logic                   restart_w;
  logic                   half_tick;
  bxt_pg_state_t          pg_state_r;
  logic [7:0]             half_cnt_r;
  logic [11:0]            gap_cnt_r;
  logic [11:0]            gap_last_w;
  logic [8:0]             lfsr_r;
  logic                   line_r;
  logic [`BXT_DATA_W-1:0] rdata_w;

  assign hit_w = (REG_ADDR == `BXT_OFS_LINE_TEST);

  // --------------------------------------------------------------------------
  // Control fields
  // --------------------------------------------------------------------------
  // Bits 15:8 are never written here, so writes to the counter are dropped.
  // Reserved bits are kept as plain storage so software reads back its value.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rsvd_hi_r <= 2'h0;
      cont_r    <= 1'b0;
      pat_en_r  <= 1'b0;
      rsvd_lo_r <= 1'b0;
      gap_sel_r <= 1'b0;
      pat_sel_r <= PAT_DATA_END_OF_PACKET_VARIANT_0;
    end else if (REG_WE && hit_w) begin
      rsvd_hi_r <= REG_WDATA[`BXT_RSVD_HI_MSB:`BXT_RSVD_HI_LSB];
      cont_r    <= REG_WDATA[`BXT_CONT_BIT];
      pat_en_r  <= REG_WDATA[`BXT_PATEN_BIT];
      rsvd_lo_r <= REG_WDATA[`BXT_RSVD_LO_BIT];
      gap_sel_r <= REG_WDATA[`BXT_GAPSEL_BIT];
      pat_sel_r <= bxt_pat_sel_t'(
                   REG_WDATA[`BXT_PATSEL_MSB:`BXT_PATSEL_LSB]);
    end
  end

  // The self-test engine keeps its gaps out while this level is high; the
  // jabber timer elsewhere must already be off for 10 Mb/s use.
  assign SELFTEST_CONTINUOUS_TX = cont_r;

  // --------------------------------------------------------------------------
  // Error nibble counter
  // --------------------------------------------------------------------------
  // A restart outranks an error in the same cycle: that nibble belongs to
  // the test being abandoned.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      err_cnt_r <= 8'h00;
    end else if (SELFTEST_START) begin
      err_cnt_r <= 8'h00;
    end else if (SELFTEST_ACTIVE && SELFTEST_RX_NIBBLE_ERR &&
                 err_cnt_r != `BXT_ERRCNT_MAX) begin
      err_cnt_r <= err_cnt_r + 8'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------------
  // Reads of any other address return zero, the counter sits in 15:8.
  always_comb begin
    rdata_w = `BXT_LINE_TEST_RESET;
    if (hit_w) begin
      rdata_w[`BXT_ERRCNT_MSB:`BXT_ERRCNT_LSB]   = err_cnt_r;
      rdata_w[`BXT_RSVD_HI_MSB:`BXT_RSVD_HI_LSB] = rsvd_hi_r;
      rdata_w[`BXT_CONT_BIT]                     = cont_r;
      rdata_w[`BXT_PATEN_BIT]                    = pat_en_r;
      rdata_w[`BXT_RSVD_LO_BIT]                  = rsvd_lo_r;
      rdata_w[`BXT_GAPSEL_BIT]                   = gap_sel_r;
      rdata_w[`BXT_PATSEL_MSB:`BXT_PATSEL_LSB]   = pat_sel_r;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      REG_RDATA  <= `BXT_LINE_TEST_RESET;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RE;
      if (REG_RE) begin
        REG_RDATA <= rdata_w;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pattern run control
  // --------------------------------------------------------------------------
  // Enabling, or changing the selection while enabled, starts the chosen
  // sequence from its beginning rather than splicing two patterns.
  assign restart_w = pat_en_r && (!run_r || run_sel_r != pat_sel_r);

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      run_r     <= 1'b0;
      run_sel_r <= PAT_DATA_END_OF_PACKET_VARIANT_0;
    end else begin
      run_r     <= pat_en_r;
      run_sel_r <= pat_sel_r;
    end
  end

  bxt_tick_div #(
    .DIV (`BXT_HALF_BIT_CYC)
  ) u_half_div (
    .REF_CLK (REF_CLK),
    .RESET   (RESET),
    .run     (pat_en_r && !restart_w),
    .tick    (half_tick)
  );

  assign gap_last_w = gap_sel_r ? GAP_LONG : GAP_SHORT;

  // --------------------------------------------------------------------------
  // Pseudo-random data source
  // --------------------------------------------------------------------------
  // A 9-bit PRBS is short but plenty to exercise the line driver.
  always_ff @(posedge REF_CLK) begin
    if (RESET || restart_w) begin
      lfsr_r <= `BXT_LFSR_SEED;
    end else if (pg_state_r == PG_DATA && half_tick && half_cnt_r[0]) begin
      lfsr_r <= {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
    end
  end

  // --------------------------------------------------------------------------
  // Pattern sequencer
  // --------------------------------------------------------------------------
  // Each half-bit tick sets the line level for the half that begins; a one
  // is sent low then high, so a constant-ones run is a 10 MHz tone.
  always_ff @(posedge REF_CLK) begin
    if (RESET || !pat_en_r) begin
      pg_state_r <= PG_OFF;
      half_cnt_r <= 8'h00;
      gap_cnt_r  <= 12'h000;
      line_r     <= 1'b0;
    end else if (restart_w) begin
      half_cnt_r <= 8'h00;
      gap_cnt_r  <= 12'h000;
      line_r     <= 1'b0;
      case (pat_sel_r)
        PAT_NLP:  pg_state_r <= PG_NLP;
        PAT_TONE: pg_state_r <= PG_TONE;
        default:  pg_state_r <= PG_DATA;
      endcase
    end else begin
      case (pg_state_r)
        PG_DATA: begin
          if (half_tick) begin
            line_r     <= half_cnt_r[0] ? lfsr_r[0] : !lfsr_r[0];
            half_cnt_r <= half_cnt_r + 8'h01;
            if (half_cnt_r == DATA_LAST) begin
              half_cnt_r <= 8'h00;
              pg_state_r <= PG_EOP;
            end
          end
        end
        PG_EOP: begin
          if (half_tick) begin
            // Variant 0 ends high, variant 1 ends low.
            line_r     <= (run_sel_r == PAT_DATA_END_OF_PACKET_VARIANT_0);
            half_cnt_r <= half_cnt_r + 8'h01;
            // The tick after the last half closes it, so it lasts a full
            // half-bit instead of being cut to one cycle.
            if (half_cnt_r == EOP_END) begin
              half_cnt_r <= 8'h00;
              line_r     <= 1'b0;
              pg_state_r <= PG_GAP;
            end
          end
        end
        PG_NLP: begin
          if (half_tick) begin
            line_r     <= 1'b1;
            half_cnt_r <= half_cnt_r + 8'h01;
            // Closed on the following tick so the pulse is two full halves.
            if (half_cnt_r == NLP_END) begin
              half_cnt_r <= 8'h00;
              line_r     <= 1'b0;
              pg_state_r <= PG_GAP;
            end
          end
        end
        PG_GAP: begin
          line_r <= 1'b0;
          if (gap_cnt_r >= gap_last_w) begin
            gap_cnt_r  <= 12'h000;
            pg_state_r <= (run_sel_r == PAT_NLP) ? PG_NLP : PG_DATA;
          end else begin
            gap_cnt_r <= gap_cnt_r + 12'h001;
          end
        end
        PG_TONE: begin
          if (half_tick) begin
            line_r <= !line_r;
          end
        end
        default: begin
          pg_state_r <= PG_OFF;
          line_r     <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Line outputs
  // --------------------------------------------------------------------------
  // With the enable clear the normal transmitter keeps the line.
  assign LINE_PATTERN_ACTIVE = (pg_state_r != PG_OFF);
  assign LINE_PATTERN_DATA   = line_r;

endmodule : bxt_top

// ===== dv/bxt_chk_sva.sv
// Concurrent checks on the ports of the line test register block.
`include "bxt_regs.svh"
module bxt_chk (
  // Clock, reset and register port
  input wire logic                   REF_CLK,
  input wire logic                   RESET,
  input wire logic [`BXT_ADDR_W-1:0] REG_ADDR,
  input wire logic [`BXT_DATA_W-1:0] REG_WDATA,
  input wire logic                   REG_WE,
  input wire logic                   REG_RE,
  input wire logic [`BXT_DATA_W-1:0] REG_RDATA,
  input wire logic                   REG_RVALID,
  // Self-test and line outputs
  input wire logic                   SELFTEST_START,
  input wire logic                   SELFTEST_CONTINUOUS_TX,
  input wire logic                   LINE_PATTERN_ACTIVE,
  input wire logic                   LINE_PATTERN_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  logic wr;
  // A write only lands at the one mapped offset.
  assign wr = REG_WE && (REG_ADDR == `BXT_OFS_LINE_TEST);
  sequence s_enable_write;
    wr && REG_WDATA[`BXT_PATEN_BIT] ##1 !REG_WE;
  endsequence
  sequence s_restart_read;
    SELFTEST_START ##1 (REG_RE && REG_ADDR == `BXT_OFS_LINE_TEST);
  endsequence
  AST_RVALID_NEXT: assert property (REG_RE |=> REG_RVALID)
    else $error("read strobe not answered one cycle later");
  AST_RVALID_CAUSE: assert property (REG_RVALID |-> $past(REG_RE))
    else $error("read valid without a read strobe");
  AST_CNT_CLEAR: assert property (
    s_restart_read |=> REG_RDATA[15:8] == 8'h00)
    else $error("error count not cleared by a restart");
  AST_CONT_FOLLOW: assert property (
    wr |=> SELFTEST_CONTINUOUS_TX == $past(REG_WDATA[`BXT_CONT_BIT]))
    else $error("continuous flag does not follow the write");
  AST_CONT_HOLD: assert property (
    !wr |=> $stable(SELFTEST_CONTINUOUS_TX))
    else $error("continuous flag moved without a write");
  AST_PAT_ON: assert property (s_enable_write |=> LINE_PATTERN_ACTIVE)
    else $error("pattern not active two cycles after enable");
  AST_PAT_OFF: assert property (
    wr && !REG_WDATA[`BXT_PATEN_BIT] |=> ##1
      (!LINE_PATTERN_ACTIVE && !LINE_PATTERN_DATA))
    else $error("pattern still on after disable");
  AST_IDLE_LOW: assert property (
    !LINE_PATTERN_ACTIVE |-> !LINE_PATTERN_DATA)
    else $error("line level driven while pattern inactive");
endmodule : bxt_chk
bind bxt_top bxt_chk i_chk (
  .REF_CLK(REF_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE),
  .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .SELFTEST_START(SELFTEST_START),
  .SELFTEST_CONTINUOUS_TX(SELFTEST_CONTINUOUS_TX),
  .LINE_PATTERN_ACTIVE(LINE_PATTERN_ACTIVE),
  .LINE_PATTERN_DATA(LINE_PATTERN_DATA)
);

// ===== dv/bxt_mgmt_model.sv
// Management controller model that reaches the line test register.
`include "bxt_regs.svh"
module bxt_mgmt_model (
  // Clock
  input  wire logic                   REF_CLK,
  // Register port
  output logic      [`BXT_ADDR_W-1:0] REG_ADDR,
  output logic      [`BXT_DATA_W-1:0] REG_WDATA,
  output logic                        REG_WE,
  output logic                        REG_RE,
  input  wire logic [`BXT_DATA_W-1:0] REG_RDATA,
  input  wire logic                   REG_RVALID
);
  timeunit 1ns;
  timeprecision 1ps;
  logic long_tx_cutoff_disable = 1'b0;
  // Quiet bus from time zero.
  initial begin
    REG_ADDR  = 5'h00;
    REG_WDATA = 16'h0000;
    REG_WE    = 1'b0;
    REG_RE    = 1'b0;
  end
  // One-cycle write; released lines are inverted so stale data never helps.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge REF_CLK);
    if (d[`BXT_CONT_BIT]) long_tx_cutoff_disable = 1'b1;
    REG_ADDR  = a;
    REG_WDATA = d & 16'hFF37;
    REG_WE    = 1'b1;
    @(negedge REF_CLK);
    REG_WE    = 1'b0;
    REG_ADDR  = ~a;
    REG_WDATA = ~REG_WDATA;
  endtask : wr
  // One-cycle read; the answer is taken while its valid pulse stands.
  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    @(negedge REF_CLK);
    REG_ADDR = a;
    REG_RE   = 1'b1;
    @(negedge REF_CLK);
    REG_RE   = 1'b0;
    REG_ADDR = ~a;
    q = (REG_RVALID === 1'b1) ? REG_RDATA : 16'hXXXX;
  endtask : rd
endmodule : bxt_mgmt_model

// ===== dv/tb_top.sv
// Self-checking bench of the self-test and line test pattern block.
`include "bxt_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   ref_clk     = 1'b0;
  logic                   reset       = 1'b1;
  logic                   st_start    = 1'b0;
  logic                   st_act      = 1'b0;
  logic                   st_err      = 1'b0;
  logic [`BXT_ADDR_W-1:0] reg_addr;
  logic [`BXT_DATA_W-1:0] reg_wdata;
  logic [`BXT_DATA_W-1:0] reg_rdata;
  logic                   reg_we;
  logic                   reg_re;
  logic                   reg_rvalid;
  logic                   cont_tx;
  logic                   pat_active;
  logic                   pat_data;
  logic [31:0]            lfsr_r      = 32'h000001A0;
  logic [15:0]            q;
  int                     n;
  int                     err_count   = 0;
  int                     comparisons = 0;
  // Free-running 200 MHz clock.
  always #2.5 ref_clk = ~ref_clk;
  bxt_top i_dut (
    .REF_CLK(ref_clk), .RESET(reset), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RE(reg_re),
    .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
    .SELFTEST_START(st_start), .SELFTEST_ACTIVE(st_act),
    .SELFTEST_RX_NIBBLE_ERR(st_err), .SELFTEST_CONTINUOUS_TX(cont_tx),
    .LINE_PATTERN_ACTIVE(pat_active), .LINE_PATTERN_DATA(pat_data)
  );
  bxt_mgmt_model i_mgmt (
    .REF_CLK(ref_clk), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WE(reg_we), .REG_RE(reg_re), .REG_RDATA(reg_rdata),
    .REG_RVALID(reg_rvalid)
  );
  // Stimulus source: 32-bit shift register with taps 32, 22, 2 and 1.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // The count sticks at all ones instead of wrapping.
  function automatic logic [15:0] exp_count(input int k);
    return (k > 255) ? 16'h00FF : 16'(k);
  endfunction : exp_count
  // Idle gap in clock cycles for the selected gap length.
  function automatic int gap_cyc(input logic g);
    return (g ? 15000 : 10000) / 5;
  endfunction : gap_cyc
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Errored-nibble pulses, each with the given self-test running level.
  task automatic pulses(input int k, input logic act);
    repeat (k) begin
      @(negedge ref_clk);
      st_act = act;
      st_err = 1'b1;
      @(negedge ref_clk);
      st_err = 1'b0;
    end
  endtask : pulses
  // Length of the current run of line level v; a line stuck for 4000 cycles fails and ends the test.
  task automatic run_len(input logic v, output int len);
    len = 0;
    while (pat_data === v && len < 4000) begin
      @(negedge ref_clk);
      len++;
    end
    if (len >= 4000) begin
      err_count++;
      tally_and_finish();
    end
  endtask : run_len
  initial begin
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    i_mgmt.rd(5'h1B, q);
    check(q, 16'h0000);
    i_mgmt.wr(5'h1A, 16'h0037);
    i_mgmt.rd(5'h1A, q);
    check(q, 16'h0000);
    i_mgmt.rd(5'h1B, q);
    check(q, 16'h0000);
    repeat (6) begin
      lfsr_r = lfsr_next(lfsr_r);
      i_mgmt.wr(5'h1B, lfsr_r[15:0]);
      i_mgmt.rd(5'h1B, q);
      check(q, {8'h00, lfsr_r[7:0] & 8'h37});
      check({15'h0000, cont_tx}, {15'h0000, lfsr_r[5]});
    end
    n = int'(lfsr_r[4:0]) + 1;
    pulses(n, 1'b1);
    pulses(3, 1'b0);
    i_mgmt.rd(5'h1B, q);
    check({8'h00, q[15:8]}, exp_count(n));
    pulses(300, 1'b1);
    i_mgmt.rd(5'h1B, q);
    check({8'h00, q[15:8]}, exp_count(n + 300));
    // Restart together with an errored nibble, read right behind it.
    @(negedge ref_clk);
    st_start = 1'b1;
    st_err   = 1'b1;
    fork
      i_mgmt.rd(5'h1B, q);
      begin
        @(negedge ref_clk);
        st_start = 1'b0;
        st_err   = 1'b0;
      end
    join
    check({8'h00, q[15:8]}, 16'h0000);
    i_mgmt.wr(5'h1B, 16'h0007);
    repeat (50) @(negedge ref_clk);
    check({14'h0000, pat_active, pat_data}, 16'h0000);
    // Every pattern, then link pulses again with the long gap.
    for (int s = 0; s < 5; s++) begin
      i_mgmt.wr(5'h1B, (s == 4) ? 16'h0016 : (16'h0010 | 16'(s)));
      repeat (2) @(negedge ref_clk);
      check({15'h0000, pat_active}, 16'h0001);
      if (s < 2) begin
        repeat (1308) @(negedge ref_clk);
        check({15'h0000, pat_data}, {15'h0000, s == 0});
      end else if (s == 3) begin
        repeat (20) @(negedge ref_clk);
        n = 0;
        repeat (200) begin
          q[0] = pat_data;
          @(negedge ref_clk);
          n += int'(pat_data !== q[0]);
        end
        check(16'(n), 16'h0014);
      end else begin
        run_len(1'b0, n);
        run_len(1'b1, n);
        check(16'(n), 16'h0014);
        run_len(1'b0, n);
        q = {15'h0000, n >= gap_cyc(s == 4) && n <= gap_cyc(s == 4) + 20};
        check(q, 16'h0001);
      end
    end
    i_mgmt.wr(5'h1B, 16'h0000);
    repeat (4) @(negedge ref_clk);
    check({14'h0000, pat_active, cont_tx}, 16'h0000);
    tally_and_finish();
  end
endmodule : tb_top
